// *** verilog/adc_ctrl.sv ***
// control, conversion timing and register slave of the converter
`timescale 1ns/1ps
module adc_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int res_width = res_w
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic filter_sync_n,
    input wire logic [res_width-1:0] sample_offset,
    output logic burnout_enable,
    output logic excitation_out_one,
    output logic excitation_out_two,
    output logic ref_sample,
    output logic mod_sample,
    output logic data_ready_n
);
    // ==========================================================
    // register state
    logic [31:0] ctrl_q;
    logic [res_width-1:0] data_q;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    logic aw_have_q;
    logic w_have_q;
    logic bvalid_q;
    logic rvalid_q;
    logic [1:0] bresp_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic rdata_sel_data_q;
    logic cal_cmd;
    logic cal_done;
    logic ctrl_hit;
    logic cal_code;
    logic wr_fire;
    logic [31:0] ctrl_d;
    logic [notch_w-1:0] notch_select;
    logic polarity_select;
    logic [2:0] operating_mode_field;
    logic [1:0] chan_sel;

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ==========================================================
    // write channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            w_q <= 32'h0000_0000;
            ws_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign ctrl_hit = (aw_q[7:2] == ctrl_off[7:2]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= ctrl_hit ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // control register with byte enables
    always_comb begin
        ctrl_d = ctrl_q;
        for (int i = 0; i < 4; i++) begin
            if (ws_q[i]) begin
                ctrl_d[8*i +: 8] = w_q[8*i +: 8];
            end
        end
    end

    // calibration command: write of a calibration mode code
    assign cal_code = w_q[mode_lsb +: mode_w] inside {md_self_cal, md_sys_zero,
        md_sys_full, md_sys_offs, md_bg_cal};
    assign cal_cmd = wr_fire && ctrl_hit && ws_q[0] && cal_code;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= ctrl_reset;
        end else if (wr_fire && ctrl_hit) begin
            ctrl_q <= ctrl_d;
        end else if (cal_done) begin
            ctrl_q[mode_lsb +: mode_w] <= (operating_mode_field == md_bg_cal)
                ? md_bg_cal : md_normal;
        end
    end

    // ==========================================================
    // control field decode
    assign notch_select = (ctrl_q[notch_lsb +: notch_w] == '0)
        ? notch_reset : ctrl_q[notch_lsb +: notch_w];
    assign polarity_select = ctrl_q[polarity_bit];
    assign operating_mode_field = ctrl_q[mode_lsb +: mode_w];
    assign chan_sel = ctrl_q[chan_lsb +: chan_w];

    // ==========================================================
    // analog switch controls
    logic [1:0] exc_drive;
    assign burnout_enable = ctrl_q[burnout_bit];
    for (genvar g = 0; g < 2; g++) begin : g_exc
        assign exc_drive[g] = ctrl_q[excitation_bit];
    end
    assign excitation_out_one = exc_drive[0];
    assign excitation_out_two = exc_drive[1];

    // ==========================================================
    // master clock dividers, scale with aclk
    logic [7:0] ref_cnt_q;
    logic [8:0] mod_cnt_q;
    logic mod_tick;
    logic ref_tick;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_cnt_q <= 8'h00;
        end else begin
            ref_cnt_q <= ref_cnt_q + 8'h01;
        end
    end
    assign ref_tick = (ref_cnt_q == 8'(ref_div - 1));

    // ==========================================================
    // filter sync edge detect and filter reset
    logic sync_prev_q;
    logic sync_fall;
    logic filt_rst;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_prev_q <= 1'b1;
        end else begin
            sync_prev_q <= filter_sync_n;
        end
    end
    assign sync_fall = sync_prev_q && !filter_sync_n;
    assign filt_rst = sync_fall || cal_cmd;

    always_ff @(posedge aclk) begin
        if (!aresetn || filt_rst) begin
            mod_cnt_q <= 9'h000;
        end else begin
            mod_cnt_q <= mod_cnt_q + 9'h001;
        end
    end
    assign mod_tick = (mod_cnt_q == 9'(mod_div - 1));

    // ==========================================================
    // sample strobes from flip-flops
    logic ref_sample_q;
    logic mod_sample_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_sample_q <= 1'b0;
            mod_sample_q <= 1'b0;
        end else begin
            ref_sample_q <= ref_tick;
            mod_sample_q <= mod_tick;
        end
    end
    assign ref_sample = ref_sample_q;
    assign mod_sample = mod_sample_q;

    // ==========================================================
    // decimation: one output word per notch period
    logic [notch_w-1:0] dec_cnt_q;
    logic out_tick;
    logic [2:0] settle_q;
    logic settled;
    always_ff @(posedge aclk) begin
        if (!aresetn || filt_rst) begin
            dec_cnt_q <= '0;
        end else if (mod_tick) begin
            dec_cnt_q <= (dec_cnt_q >= notch_select - 1'b1) ? '0 : dec_cnt_q + 1'b1;
        end
    end
    assign out_tick = mod_tick && (dec_cnt_q >= notch_select - 1'b1);

    // ==========================================================
    // settle counter: four periods after filter reset
    always_ff @(posedge aclk) begin
        if (!aresetn || filt_rst) begin
            settle_q <= 3'h0;
        end else if (out_tick && !settled) begin
            settle_q <= settle_q + 3'h1;
        end
    end
    assign settled = (settle_q >= 3'(settle_periods - 1));

    // ==========================================================
    // calibration sequencing: conversions counted in output periods
    logic cal_busy_q;
    logic [2:0] cal_cnt_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_busy_q <= 1'b0;
            cal_cnt_q <= 3'h0;
        end else if (cal_cmd) begin
            cal_busy_q <= 1'b1;
            cal_cnt_q <= 3'h0;
        end else if (cal_busy_q && out_tick && settled) begin
            cal_cnt_q <= cal_cnt_q + 3'h1;
            if (cal_cnt_q == 3'(cal_conv - 1)) begin
                cal_busy_q <= 1'b0;
            end
        end
    end
    assign cal_done = cal_busy_q && out_tick && settled && (cal_cnt_q == 3'(cal_conv - 1));

    // ==========================================================
    // output coding and data register
    logic bipolar;
    logic [res_width-1:0] coded;
    logic word_new;
    logic rd_clear;
    assign bipolar = polarity_select && (chan_sel != ch_high_level);
    assign coded = bipolar
        ? {~sample_offset[res_width-1], sample_offset[res_width-2:0]}
        : sample_offset;
    assign word_new = out_tick && settled && !cal_busy_q;
    assign rd_clear = rvalid_q && s_axi_rready && rdata_sel_data_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= '0;
        end else if (word_new) begin
            data_q <= coded;
        end
    end

    // ==========================================================
    // data ready: high during calibration and settling, low on fresh word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_ready_n <= 1'b1;
        end else if (cal_done) begin
            data_ready_n <= 1'b0;
        end else if (filt_rst) begin
            data_ready_n <= 1'b1;
        end else if (word_new) begin
            data_ready_n <= 1'b0;
        end else if (rd_clear) begin
            data_ready_n <= 1'b1;
        end
    end

    // ==========================================================
    // read channel, any time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
            rdata_sel_data_q <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= 2'h0;
            rdata_sel_data_q <= 1'b0;
            unique case (s_axi_araddr[7:2])
                ctrl_off[7:2]: rdata_q <= ctrl_q;
                data_off[7:2]: begin
                    rdata_q <= 32'(data_q);
                    rdata_sel_data_q <= 1'b1;
                end
                status_off[7:2]: rdata_q <= {28'h0, settled, cal_busy_q, 1'b0, data_ready_n};
                rate_off[7:2]: rdata_q <= 32'(notch_select);
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule

// *** verilog/adc_ctrl_pkg.sv ***
// constants for the converter control and synchronisation block
package adc_ctrl_pkg;
    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] data_off = 8'h04;
    localparam logic [7:0] status_off = 8'h08;
    localparam logic [7:0] rate_off = 8'h0c;
    // ==========================================================
    // control field positions
    localparam int burnout_bit = 0;
    localparam int excitation_bit = 1;
    localparam int polarity_bit = 2;
    localparam int mode_lsb = 4;
    localparam int mode_w = 3;
    localparam int chan_lsb = 8;
    localparam int chan_w = 2;
    localparam int notch_lsb = 16;
    localparam int notch_w = 12;
    // ==========================================================
    // reset values
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [11:0] notch_reset = 12'h180;
    // ==========================================================
    // timing counts and data width
    localparam int ref_div = 256;
    localparam int mod_div = 512;
    localparam int settle_periods = 4;
    localparam int cal_conv = 2;
    localparam int res_w = 24;
    // ==========================================================
    // operating modes
    typedef enum logic [2:0] {
        md_normal = 3'b000,
        md_self_cal = 3'b001,
        md_sys_zero = 3'b010,
        md_sys_full = 3'b011,
        md_sys_offs = 3'b100,
        md_bg_cal = 3'b101
    } op_mode_e;
    // channel codes
    localparam logic [1:0] ch_diff_one = 2'h0;
    localparam logic [1:0] ch_diff_two = 2'h1;
    localparam logic [1:0] ch_high_level = 2'h2;
endpackage

// *** tb/sync_host.sv ***
// host model driving the shared filter sync line
`timescale 1ns/1ps
module sync_host #(
    parameter int low_cycles = 4
) (
    input wire logic aclk,
    input wire logic go,
    output logic filter_sync_n
);
    int cnt_q = 0;
    // one low pulse per request, common to all devices
    always @(posedge aclk) begin
        if (go) begin
            cnt_q <= low_cycles;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign filter_sync_n = (cnt_q == 0);
endmodule

// *** tb/adc_ctrl_asserts.sv ***
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module adc_ctrl_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic filter_sync_n,
    input wire logic burnout_enable,
    input wire logic excitation_out_one,
    input wire logic excitation_out_two,
    input wire logic ref_sample,
    input wire logic mod_sample,
    input wire logic data_ready_n
);
    // ==========================================================
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_EXC_PAIR: assert property (excitation_out_one == excitation_out_two)
        else $error("excitation outputs differ");
    AST_BURN_WR: assert property ($changed(burnout_enable)
        |-> s_axi_bvalid && !s_axi_bresp)
        else $error("burnout changed without write");
    AST_EXC_WR: assert property ($changed(excitation_out_one) |-> s_axi_bvalid)
        else $error("excitation changed without write");
    AST_REF_PER: assert property (ref_sample |-> ##256 ref_sample)
        else $error("reference sample period wrong");
    AST_MOD_PULSE: assert property (mod_sample |=> !mod_sample [*8])
        else $error("modulator pulse too long");
    AST_SYNC_DATA_READY_N: assert property ($fell(filter_sync_n) |-> ##[0:2] data_ready_n)
        else $error("sync did not clear ready");
    AST_SYNC_QUIET: assert property ($fell(filter_sync_n) |-> ##3 data_ready_n [*8])
        else $error("ready during settling");
    AST_RD_CLR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
        |-> ##[1:3] data_ready_n)
        else $error("data read did not clear ready");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    cover property ($fell(data_ready_n));
    cover property ($fell(filter_sync_n));
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
    import adc_ctrl_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go = 1'b0;
    logic [23:0] sample_offset = 24'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic filter_sync_n, burnout_enable, excitation_out_one, excitation_out_two;
    logic ref_sample, mod_sample, data_ready_n;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    always #50 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    adc_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .filter_sync_n,
        .sample_offset, .burnout_enable, .excitation_out_one, .excitation_out_two,
        .ref_sample, .mod_sample, .data_ready_n);
    sync_host u_host (.aclk, .go, .filter_sync_n);
    // ==========================================================
    // checking and bus tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tk;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tk = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            s_axi_bready <= !tk;
        end while (!tk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tk;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($urandom_range(1));
        do begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tk = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            s_axi_rready <= !tk;
        end while (!tk);
    endtask
    task automatic wait_rdy(input logic v, input int lim, output int n);
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (data_ready_n !== v && n < lim);
        chk("ready level", {31'h0, v}, {31'h0, data_ready_n});
    endtask
    function automatic logic [31:0] cw(logic bo, ex, pol, logic [2:0] m, logic [1:0] ch);
        return {4'h0, 12'h001, 6'h00, ch, 1'b0, m, 1'b0, pol, ex, bo};
    endfunction
    function automatic logic [31:0] exp_data(logic [23:0] s, logic pol, logic [1:0] ch);
        return {8'h00, (pol && ch != ch_high_level) ? {~s[23], s[22:0]} : s};
    endfunction
    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] d, w;
        logic [1:0] r;
        logic pol;
        int n, t1;
        void'($urandom(5129));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            w = cw(i[0], i[1], 1'($urandom), 3'h0, 2'($urandom_range(2)));
            wr(ctrl_off, w, r);
            chk("burnout", {31'h0, w[0]}, {31'h0, burnout_enable});
            chk("excite one", {31'h0, w[1]}, {31'h0, excitation_out_one});
            chk("excite two", {31'h0, w[1]}, {31'h0, excitation_out_two});
            rd(ctrl_off, d, r);
            chk("ctrl read", w, d);
        end
        $display("test control done");
        rd(8'h10, d, r);
        chk("unmapped rresp", 32'h2, {30'h0, r});
        wr(data_off, 32'h1, r);
        chk("data write resp", 32'h2, {30'h0, r});
        $display("test refusal done");
        for (int k = 0; k < 3; k++) begin
            pol = (k != 0);
            sample_offset <= 24'($urandom);
            wr(ctrl_off, cw(1'b0, 1'b0, pol, 3'h0, 2'(k)), r);
            go <= 1'b1;
            @(posedge aclk);
            go <= 1'b0;
            wait_rdy(1'b1, 4, n);
            wait_rdy(1'b0, 6 * mod_div, n);
            chk("settled late", 32'h1, {31'h0, n > 4 * mod_div - 16});
            t1 = cyc;
            rd(data_off, d, r);
            chk("data", exp_data(sample_offset, pol, 2'(k)), d);
            wait_rdy(1'b0, 2 * mod_div, n);
            chk("period", 32'(mod_div), 32'(cyc - t1));
        end
        $display("test coding done");
        for (int m = 1; m <= 5; m++) begin
            pol = 1'($urandom);
            wr(ctrl_off, cw(1'b1, 1'b1, pol, 3'(m), 2'h0), r);
            wait_rdy(1'b1, mod_div, n);
            wait_rdy(1'b0, 8 * mod_div, n);
            rd(ctrl_off, d, r);
            w = cw(1'b1, 1'b1, pol, (m == 5) ? 3'(md_bg_cal) : 3'h0, 2'h0);
            chk("mode back", w, d);
        end
        $display("test calibration done");
        test_done();
    end
    initial begin
        repeat (60000) @(posedge aclk);
        error_cnt++;
        test_done();
    end
endmodule
bind adc_ctrl adc_ctrl_asserts u_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
    .s_axi_bvalid, .filter_sync_n, .burnout_enable, .excitation_out_one,
    .excitation_out_two, .ref_sample, .mod_sample, .data_ready_n);
